// [rtl/ssu_consts.vh]
`ifndef SSU_CONSTS_VH
`define SSU_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define SSU_OFS_CONTROL_ONE 8'h00
`define SSU_OFS_STATUS 8'h04
`define SSU_OFS_BUFFER 8'h08
`define SSU_OFS_IRQ 8'h0C
`define SSU_OFS_PIN_CFG 8'h10

// ****************************************
// serial_control_one fields
// ****************************************
`define SSU_CTRL_WRITE_COLLISION_FLAG 7
`define SSU_CTRL_OVF 6
`define SSU_CTRL_EN 5
`define SSU_CTRL_CPOL 4
`define SSU_CTRL_MODE_HI 3
`define SSU_CTRL_MODE_LO 0

// ****************************************
// serial_status fields
// ****************************************
`define SSU_STAT_SMP 7
`define SSU_STAT_CKE 6
`define SSU_STAT_BF 0

// ****************************************
// irq and pin config fields
// ****************************************
`define SSU_IRQ_FLAG 0
`define SSU_IRQ_ENABLE 1
`define SSU_PIN_SDO_INPUT 0

// ****************************************
// reset values
// ****************************************
`define SSU_RST_CONTROL_ONE 8'h00
`define SSU_RST_STATUS 8'h00
`define SSU_RST_BUFFER 8'h00

// ****************************************
// port_mode_select codes
// ****************************************
`define SSU_MODE_MST_DIV4 4'h0
`define SSU_MODE_MST_DIV16 4'h1
`define SSU_MODE_MST_DIV64 4'h2
`define SSU_MODE_MST_TIMER 4'h3
`define SSU_MODE_SLV_SS 4'h4
`define SSU_MODE_SLV_FREE 4'h5

// ****************************************
// timing: core cycles per half bit period, bits and clock edges per byte
// ****************************************
`define SSU_HALF_DIV4 6'h02
`define SSU_HALF_DIV16 6'h08
`define SSU_HALF_DIV64 6'h20
`define SSU_BITS_PER_BYTE 4'h8
`define SSU_EDGES_PER_BYTE 5'h10

`endif

// [rtl/ssu_rate_gen.v]
`timescale 1ns/100ps
`default_nettype none
`include "ssu_consts.vh"

module ssu_rate_gen (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire clear_i,
  input wire hold_i,
  input wire [1:0] rate_i,
  input wire timer_tick_i,
  output reg tick_o
);

  // ****************************************
  // half bit period divider
  // ****************************************
  reg [5:0] count;
  reg [5:0] half;

  always @* begin
    case (rate_i)
      2'h0: half = `SSU_HALF_DIV4;
      2'h1: half = `SSU_HALF_DIV16;
      default: half = `SSU_HALF_DIV64;
    endcase
  end

  // hold freezes the count so a sleeping transfer resumes in place
  always @(posedge core_clk_i) begin
    if (!reset_n_i || clear_i) begin
      count <= 6'h00;
      tick_o <= 1'b0;
    end else if (hold_i) begin
      tick_o <= 1'b0;
    end else if (rate_i == 2'h3) begin
      tick_o <= timer_tick_i;
    end else if (count == half - 6'h01) begin
      count <= 6'h00;
      tick_o <= 1'b1;
    end else begin
      count <= count + 6'h01;
      tick_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// [rtl/ssu_pin_edge.v]
`timescale 1ns/100ps
`default_nettype none

module ssu_pin_edge (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire sck_i,
  input wire sdi_i,
  input wire ss_n_i,
  output reg sdi_q_o,
  output reg ss_n_q_o,
  output wire sck_rise_o,
  output wire sck_fall_o
);

  // ****************************************
  // pin capture and clock edge detect
  // ****************************************
  reg sck_q;
  reg sck_prev;

  // ss resets high so a reset never looks like a selected slave
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sck_q <= 1'b0;
      sck_prev <= 1'b0;
      sdi_q_o <= 1'b0;
      ss_n_q_o <= 1'b1;
    end else begin
      sck_q <= sck_i;
      sck_prev <= sck_q;
      sdi_q_o <= sdi_i;
      ss_n_q_o <= ss_n_i;
    end
  end

  assign sck_rise_o = sck_q & ~sck_prev;
  assign sck_fall_o = ~sck_q & sck_prev;

endmodule
`default_nettype wire

// [rtl/ssu_top.v]
// Function
// - select gating only in mode code 4
// - select low enables shifting, drives output
// - select high floats output two clocks later
// - select high resets port in mode 4
// - port reset zeroes bit counter
// - output configured input: receive only
// - master freezes in sleep, then resumes
// - master completion wakes when interrupt enabled
// - slave shifts independent of sleep
// - slave byte sets flag, may wake
// - device reset disables port, aborts transfer
// - polarity and edge bits give SPI modes
// - sample phase bit moves input sampling in master modes
// - four mode bits pick role, rate
// - polarity bit sets clock idle level
// - msb first, byte to buffer, flags
// - write while shifting dropped, collision flag
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "ssu_consts.vh"

module ssu_top (
  input wire core_clk_i,
  input wire reset_n_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe_o,
  input wire sdi_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  input wire ss_n_i,
  input wire timer_tick_i,
  input wire sleep_i,
  output reg wake_o
);

  localparam M_IDLE = 1'b0;
  localparam M_RUN = 1'b1;

  // ****************************************
  // state
  // ****************************************
  reg [7:0] serial_control_one;
  reg sample_phase;
  reg cke;
  reg buffer_full_flag;
  reg [7:0] serial_buffer;
  reg [7:0] tx_shift;
  reg [7:0] serial_shift_register;
  reg port_interrupt_flag;
  reg port_interrupt_enable;
  reg sdo_as_input;
  reg m_state;
  reg [4:0] edge_cnt;
  reg [3:0] bit_cnt;
  reg late_pend;
  reg seen_out;
  reg sck_drv;
  reg [1:0] m_samp_dly;

  wire sdi_q;
  wire ss_n_q;
  wire sck_rise;
  wire sck_fall;
  wire tick;

  wire port_enable = serial_control_one[`SSU_CTRL_EN];
  wire clock_polarity = serial_control_one[`SSU_CTRL_CPOL];
  wire [3:0] port_mode_select = serial_control_one[`SSU_CTRL_MODE_HI:`SSU_CTRL_MODE_LO];
  wire write_collision_flag = serial_control_one[`SSU_CTRL_WRITE_COLLISION_FLAG];
  wire receive_overflow_flag = serial_control_one[`SSU_CTRL_OVF];

  // ****************************************
  // mode decode
  // ****************************************
  wire is_master = (port_mode_select <= `SSU_MODE_MST_TIMER);
  wire is_slave_ss = (port_mode_select == `SSU_MODE_SLV_SS);
  wire is_slave_free = (port_mode_select == `SSU_MODE_SLV_FREE);
  wire mode_valid = is_master | is_slave_ss | is_slave_free;
  // codes above 5 belong to the two-wire mode and keep the port idle
  wire port_rst = ~port_enable | ~mode_valid | (is_slave_ss & ss_n_q);
  wire slave_act = ~port_rst & (is_slave_free | is_slave_ss);

  // ****************************************
  // pins and rate
  // ****************************************
  ssu_pin_edge u_pin (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .sck_i(sck_i),
    .sdi_i(sdi_i),
    .ss_n_i(ss_n_i),
    .sdi_q_o(sdi_q),
    .ss_n_q_o(ss_n_q),
    .sck_rise_o(sck_rise),
    .sck_fall_o(sck_fall)
  );

  ssu_rate_gen u_rate (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(m_state == M_IDLE),
    .hold_i(sleep_i),
    .rate_i(port_mode_select[1:0]),
    .timer_tick_i(timer_tick_i),
    .tick_o(tick)
  );

  // ****************************************
  // edge classification
  // ****************************************
  wire m_tick = ~port_rst & is_master & (m_state == M_RUN) & tick;
  wire m_toggle = m_tick & (edge_cnt < `SSU_EDGES_PER_BYTE);
  wire m_lead = m_toggle & (sck_drv == clock_polarity);
  wire m_trail = m_toggle & (sck_drv != clock_polarity);
  // slave edges come from the pin, so sleep has no effect on them
  wire s_lead = slave_act & (clock_polarity ? sck_fall : sck_rise);
  wire s_trail = slave_act & (clock_polarity ? sck_rise : sck_fall);
  wire ev_lead = is_master ? m_lead : s_lead;
  wire ev_trail = is_master ? m_trail : s_trail;
  wire out_ev = cke ? ev_trail : ev_lead;
  wire samp_norm = cke ? ev_lead : ev_trail;
  // late sampling is master only; master samples wait out the clock and data pin flops
  wire late_mode = is_master & sample_phase;
  wire m_samp = late_mode ? (late_pend & m_tick) : m_samp_dly[1];
  wire samp_ev = (is_master ? m_samp : samp_norm) & (bit_cnt < `SSU_BITS_PER_BYTE);
  wire shift_out = out_ev & (cke | seen_out);
  wire byte_done = samp_ev & (bit_cnt == `SSU_BITS_PER_BYTE - 4'h1);
  wire m_end = m_tick & (edge_cnt == `SSU_EDGES_PER_BYTE) & ~late_pend & ~(|m_samp_dly);
  wire [7:0] rx_next = {serial_shift_register[6:0], sdi_q};

  // ****************************************
  // bus decode
  // ****************************************
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_acc = bus_req & wb_we_i & wb_sel_i[0];
  wire rd_acc = bus_req & ~wb_we_i;
  wire [7:0] wdat = wb_dat_i[7:0];
  wire busy = is_master ? (m_state == M_RUN) : (bit_cnt != 4'h0);
  wire buf_wr = wr_acc & (wb_adr_i == `SSU_OFS_BUFFER);
  wire buf_rd = rd_acc & (wb_adr_i == `SSU_OFS_BUFFER);
  wire write_collision_flag_set = buf_wr & busy;
  wire buf_take = buf_wr & ~busy;
  wire ovf_set = byte_done & ~is_master & buffer_full_flag & ~buf_rd;
  wire ctrl_wr = wr_acc & (wb_adr_i == `SSU_OFS_CONTROL_ONE);
  wire irq_wr = wr_acc & (wb_adr_i == `SSU_OFS_IRQ);

  reg [7:0] next_control;
  reg next_flag;

  // flags only software clears, by writing zero; a set in the same cycle wins
  always @* begin
    next_control = serial_control_one;
    if (ctrl_wr) begin
      next_control[5:0] = wdat[5:0];
      next_control[`SSU_CTRL_WRITE_COLLISION_FLAG] = write_collision_flag & wdat[`SSU_CTRL_WRITE_COLLISION_FLAG];
      next_control[`SSU_CTRL_OVF] = receive_overflow_flag & wdat[`SSU_CTRL_OVF];
    end
    if (write_collision_flag_set) next_control[`SSU_CTRL_WRITE_COLLISION_FLAG] = 1'b1;
    if (ovf_set) next_control[`SSU_CTRL_OVF] = 1'b1;
    next_flag = port_interrupt_flag;
    if (irq_wr) begin
      next_flag = port_interrupt_flag & wdat[`SSU_IRQ_FLAG];
    end
    if (byte_done) begin
      next_flag = 1'b1;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      serial_control_one <= `SSU_RST_CONTROL_ONE;
      sample_phase <= 1'b0;
      cke <= 1'b0;
      port_interrupt_flag <= 1'b0;
      port_interrupt_enable <= 1'b0;
      sdo_as_input <= 1'b0;
    end else begin
      serial_control_one <= next_control;
      port_interrupt_flag <= next_flag;
      if (wr_acc && wb_adr_i == `SSU_OFS_STATUS) begin
        sample_phase <= wdat[`SSU_STAT_SMP];
        cke <= wdat[`SSU_STAT_CKE];
      end
      if (irq_wr) begin
        port_interrupt_enable <= wdat[`SSU_IRQ_ENABLE];
      end
      if (wr_acc && wb_adr_i == `SSU_OFS_PIN_CFG) begin
        sdo_as_input <= wdat[`SSU_PIN_SDO_INPUT];
      end
    end
  end

  // ****************************************
  // buffer and full flag
  // ****************************************
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      serial_buffer <= `SSU_RST_BUFFER;
      buffer_full_flag <= 1'b0;
    end else if (!port_enable) begin
      buffer_full_flag <= 1'b0;
    end else if (byte_done && !ovf_set) begin
      serial_buffer <= rx_next;
      buffer_full_flag <= 1'b1;
    end else if (buf_rd) begin
      buffer_full_flag <= 1'b0;
    end
  end

  // ****************************************
  // shift engine
  // ****************************************
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      m_state <= M_IDLE;
      edge_cnt <= 5'h00;
      bit_cnt <= 4'h0;
      late_pend <= 1'b0;
      seen_out <= 1'b0;
      sck_drv <= 1'b0;
      tx_shift <= 8'h00;
      serial_shift_register <= 8'h00;
      m_samp_dly <= 2'h0;
    end else begin
      if (buf_take) begin
        tx_shift <= wdat;
      end else if (shift_out) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
      m_samp_dly <= port_rst ? 2'h0 : {m_samp_dly[0], ~late_mode & samp_norm & is_master};
      if (port_rst) begin
        // a partial byte is abandoned; the next frame starts clean
        m_state <= M_IDLE;
        edge_cnt <= 5'h00;
        bit_cnt <= 4'h0;
        late_pend <= 1'b0;
        seen_out <= 1'b0;
        sck_drv <= clock_polarity;
      end else begin
        if (samp_ev) begin
          serial_shift_register <= rx_next;
          bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
        end
        if (out_ev) begin
          seen_out <= ~byte_done;
        end else if (byte_done) begin
          seen_out <= 1'b0;
        end
        if (late_mode && samp_norm) begin
          late_pend <= 1'b1;
        end else if (samp_ev) begin
          late_pend <= 1'b0;
        end
        case (m_state)
          M_IDLE: begin
            sck_drv <= clock_polarity;
            edge_cnt <= 5'h00;
            if (buf_take && is_master) begin
              m_state <= M_RUN;
              seen_out <= 1'b0;
            end
          end
          M_RUN: begin
            if (m_toggle) begin
              sck_drv <= ~sck_drv;
              edge_cnt <= edge_cnt + 5'h01;
            end
            if (m_end) begin
              m_state <= M_IDLE;
            end
          end
          default: m_state <= M_IDLE;
        endcase
      end
    end
  end

  // ****************************************
  // pins and wake
  // ****************************************
  // one cycle after the registered select, since every output is a flop
  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      sck_o <= 1'b0;
      sck_oe_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      sdo_o <= tx_shift[7];
      sdo_oe_o <= ~port_rst & ~sdo_as_input & (is_master | slave_act);
      sck_o <= is_master ? sck_drv : clock_polarity;
      sck_oe_o <= port_enable & is_master;
      wake_o <= next_flag & port_interrupt_enable;
    end
  end

  // ****************************************
  // wishbone answer
  // ****************************************
  reg [7:0] rd_mux;

  always @* begin
    case (wb_adr_i)
      `SSU_OFS_CONTROL_ONE: rd_mux = serial_control_one;
      `SSU_OFS_STATUS: rd_mux = {sample_phase, cke, 5'h00, buffer_full_flag};
      `SSU_OFS_BUFFER: rd_mux = serial_buffer;
      `SSU_OFS_IRQ: rd_mux = {6'h00, port_interrupt_enable, port_interrupt_flag};
      `SSU_OFS_PIN_CFG: rd_mux = {7'h00, sdo_as_input};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_acc ? {24'h000000, rd_mux} : 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// [verif/ssu_top_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// port checks
// ********
module ssu_top_asserts (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic sck_oe_o,
  input wire logic sdo_oe_o,
  input wire logic ss_n_i
);
  logic [7:0] ctl;
  logic pin_in;
  logic [1:0] age;
  wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
  // settle time after a config write, so outputs may catch up
  wire logic on = ctl[5] && age == 2'h3;
  wire logic slv4 = on && ctl[3:0] == 4'h4 && !pin_in;
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ctl <= 8'h00;
      pin_in <= 1'b0;
      age <= 2'h0;
    end else if (wr && (wb_adr_i == 8'h00 || wb_adr_i == 8'h10)) begin
      if (wb_adr_i == 8'h00) ctl <= wb_dat_i[7:0];
      else pin_in <= wb_dat_i[0];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked next cycle");
  chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_dat_quiet: assert property (wb_dat_o[31:8] == 24'h0 && (wb_ack_o || wb_dat_o[7:0] == 8'h00))
    else $error("read data outside ack");
  chk_sdo_float: assert property ((slv4 && ss_n_i)[*3] |-> !sdo_oe_o)
    else $error("data out driven while deselected");
  chk_sdo_drive: assert property ((slv4 && !ss_n_i)[*3] |-> sdo_oe_o)
    else $error("data out not driven while selected");
  chk_off_quiet: assert property (!ctl[5] && age == 2'h3 |-> !sdo_oe_o && !sck_oe_o)
    else $error("disabled port drives a pin");
  chk_sdo_input: assert property (pin_in && age == 2'h3 |-> !sdo_oe_o)
    else $error("data out driven in receive only");
  chk_sck_role: assert property (on |-> sck_oe_o == (ctl[3:0] < 4'h4))
    else $error("clock drive not per mode");
endmodule
bind ssu_top ssu_top_asserts u_ssu_top_asserts (
  .core_clk_i(core_clk_i),
  .reset_n_i(reset_n_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_sel_i(wb_sel_i),
  .wb_we_i(wb_we_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .sck_oe_o(sck_oe_o),
  .sdo_oe_o(sdo_oe_o),
  .ss_n_i(ss_n_i)
);
`default_nettype wire

// [verif/ssu_spi_peer.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// far side spi peer
// ********
module ssu_spi_peer (
  input wire logic core_clk_i,
  input wire logic dev_sck_i,
  input wire logic dev_sdo_i,
  input wire logic role_mst_i,
  output logic sck_o,
  output logic ss_n_o,
  output logic sdi_o
);
  logic [7:0] tx;
  logic [7:0] rx;
  logic sk_q;
  wire logic sk = role_mst_i ? sck_o : dev_sck_i;
  assign sdi_o = tx[7];
  initial begin
    sck_o = 1'b0;
    ss_n_o = 1'b1;
    tx = 8'h00;
    rx = 8'h00;
    sk_q = 1'b0;
  end
  // spi mode 0,0: sample on rise, shift on fall
  always @(posedge core_clk_i) begin
    sk_q <= sk;
    if (sk && !sk_q) rx <= {rx[6:0], dev_sdo_i};
    if (!sk && sk_q) tx <= {tx[6:0], 1'b0};
  end
  task automatic load(input logic [7:0] b);
    tx <= b;
  endtask
  // clock stands still outside frames; half period kept slow for pin sync
  task automatic frame(input logic [7:0] b, input int nb);
    load(b);
    @(posedge core_clk_i);
    ss_n_o <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    for (int i = 0; i < nb; i++) begin
      sck_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      sck_o <= 1'b0;
      repeat (4) @(posedge core_clk_i);
    end
    ss_n_o <= 1'b1;
    @(posedge core_clk_i);
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
// ********
// bench
// ********
module tb_top;
  logic core_clk_i;
  logic reset_n_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic wb_we_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic timer_tick_i;
  logic sleep_i;
  logic role_mst;
  wire logic [31:0] wb_dat_o;
  wire logic wb_ack_o;
  wire logic sck_o;
  wire logic sck_oe_o;
  wire logic sdo_o;
  wire logic sdo_oe_o;
  wire logic wake_o;
  wire logic p_sck;
  wire logic p_ss_n;
  wire logic p_sdi;
  // pull-up assumed on the data line
  wire logic sdo_w = sdo_oe_o ? sdo_o : 1'b1;
  int err_total;
  int n_checks;
  logic [7:0] q;
  logic [7:0] v;
  ssu_top u_ssu_top (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_i(p_sck), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sdi_i(p_sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ss_n_i(p_ss_n),
    .timer_tick_i(timer_tick_i), .sleep_i(sleep_i), .wake_o(wake_o));
  ssu_spi_peer u_ssu_spi_peer (.core_clk_i(core_clk_i), .dev_sck_i(sck_o), .dev_sdo_i(sdo_w),
    .role_mst_i(role_mst), .sck_o(p_sck), .ss_n_o(p_ss_n), .sdi_o(p_sdi));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) timer_tick_i <= ~timer_tick_i;
  task automatic print_verdict;
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o[7:0];
    if (n == 40) cmp(8'h00, 8'hFF);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    cmp(q, e);
  endtask
  task automatic wait_full;
    int c;
    c = 0;
    do begin
      bus(1'b0, 8'h04, 8'h00);
      c++;
    end while (q[0] !== 1'b1 && c < 60);
    if (c == 60) cmp(8'h00, 8'hFF);
  endtask
  // whole run is under a thousand cycles; this limit is 40000 cycles
  initial begin
    #200000;
    err_total++;
    print_verdict;
  end
  initial begin
    reset_n_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'hF;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    timer_tick_i = 1'b0;
    sleep_i = 1'b0;
    role_mst = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    rd(8'h14, 8'h00);
    for (int k = 0; k < 12; k++) begin
      v = 8'h20 | {4'h0, 4'(k % 6)} | (k > 5 ? 8'h10 : 8'h00);
      wr(8'h00, v);
      rd(8'h00, v);
      cmp({7'h0, sck_oe_o}, {7'h0, k % 6 < 4});
      if (k % 6 < 4) cmp({7'h0, sck_o}, {7'h0, k > 5});
    end
    wr(8'h04, 8'h40);
    wr(8'h00, 8'h20);
    wr(8'h0C, 8'h02);
    u_ssu_spi_peer.load(8'h3C);
    wr(8'h08, 8'hA5);
    wr(8'h08, 8'h5A);
    sleep_i <= 1'b1;
    repeat (40) @(posedge core_clk_i);
    rd(8'h04, 8'h40);
    sleep_i <= 1'b0;
    wait_full;
    rd(8'h00, 8'hA0);
    cmp(u_ssu_spi_peer.rx, 8'hA5);
    rd(8'h04, 8'h41);
    rd(8'h0C, 8'h03);
    cmp({7'h0, wake_o}, 8'h01);
    rd(8'h08, 8'h3C);
    rd(8'h04, 8'h40);
    wr(8'h00, 8'h20);
    wr(8'h0C, 8'h00);
    wr(8'h10, 8'h01);
    u_ssu_spi_peer.load(8'hC3);
    wr(8'h08, 8'h77);
    wait_full;
    cmp({7'h0, wake_o}, 8'h00);
    cmp(u_ssu_spi_peer.rx, 8'hFF);
    rd(8'h0C, 8'h01);
    rd(8'h08, 8'hC3);
    wr(8'h10, 8'h00);
    wr(8'h04, 8'hC0);
    u_ssu_spi_peer.load(8'h5B);
    wr(8'h08, 8'h2D);
    wait_full;
    cmp(u_ssu_spi_peer.rx, 8'h2D);
    rd(8'h04, 8'hC1);
    rd(8'h08, 8'h5B);
    wr(8'h04, 8'h40);
    role_mst <= 1'b1;
    wr(8'h0C, 8'h02);
    wr(8'h00, 8'h24);
    wr(8'h08, 8'h96);
    sleep_i <= 1'b1;
    u_ssu_spi_peer.frame(8'h69, 8);
    wait_full;
    sleep_i <= 1'b0;
    cmp(u_ssu_spi_peer.rx, 8'h96);
    cmp({7'h0, wake_o}, 8'h01);
    rd(8'h08, 8'h69);
    wr(8'h08, 8'hF0);
    u_ssu_spi_peer.frame(8'h00, 3);
    u_ssu_spi_peer.frame(8'h81, 8);
    wait_full;
    rd(8'h08, 8'h81);
    role_mst <= 1'b0;
    wr(8'h00, 8'h20);
    wr(8'h08, 8'h11);
    reset_n_i <= 1'b0;
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
